// ### crxeq_pkg.sv
package crxeq_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam int          NUM_CHANNELS   = 4;
  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam logic [6:0]  CH0_CTRL_OFS   = 7'h00;
  localparam logic [6:0]  CH1_CTRL_OFS   = 7'h10;
  localparam logic [6:0]  CH2_CTRL_OFS   = 7'h20;
  localparam logic [6:0]  CH3_CTRL_OFS   = 7'h30;
  localparam logic [6:0]  CH_STRIDE_MASK = 7'h4f;
  localparam logic [6:0]  CH_CTRL_MATCH  = 7'h00;
  localparam int          CH_SEL_LSB     = 4;
  // ************************************************************
  // field layout
  // ************************************************************
  localparam int          RXON_POS       = 5;
  localparam int          EQC_LSB        = 0;
  localparam int          EQC_W          = 5;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_WMASK     = 8'hff;

  typedef struct packed {
    logic       rsvd7;
    logic       rsvd6;
    logic       receiverPowerOn;
    logic [4:0] equalizerControl;
  } crxeq_ctrl_type;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [6:0] addr;
    logic [7:0] wdata;
  } crxeq_req_type;
endpackage : crxeq_pkg

// ### crxeq_regfile.sv
`timescale 1ns/1ns
`default_nettype none
module crxeq_regfile #(
  parameter int DEPTH = 4
) (
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  input  wire logic                       clkEn,
  input  wire logic                       wrEn,
  input  wire logic [$clog2(DEPTH)-1:0]   wrIdx,
  input  wire logic [7:0]                 wrData,
  input  wire logic [$clog2(DEPTH)-1:0]   rdIdx,
  output logic      [7:0]                 rdData_ff,
  output logic      [DEPTH*8-1:0]         allRegs
);
  logic [7:0] mem_ff [DEPTH];

  // ************************************************************
  // storage, reset to zero
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= crxeq_pkg::CTRL_RESET; // see R6
      end
      rdData_ff <= crxeq_pkg::CTRL_RESET;
    end else if (clkEn) begin
      if (wrEn) begin
        mem_ff[wrIdx] <= wrData & crxeq_pkg::CTRL_WMASK;
      end
      rdData_ff <= mem_ff[rdIdx];
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      allRegs[i*8 +: 8] = mem_ff[i];
    end
  end
endmodule : crxeq_regfile
`default_nettype wire

// ### channel_rx_enable_eq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1: writing one powers up channel receiver
// R2: writing zero shuts down channel receiver
// R3: each bit drives only its channel
// R4: hardware mode forces all receivers on
// R5: bits four to zero form equalizer field
// R6: reset clears receiver bit and field
module channel_rx_enable_eq_ctrl #(
  parameter int NCH = crxeq_pkg::NUM_CHANNELS
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 clkEn,
  input  wire logic                 hardwareMode,
  input  wire crxeq_pkg::crxeq_req_type hostReq,
  output logic      [7:0]           rdData,
  output logic                      rdHit,
  output logic      [NCH-1:0]       receiverPowerOn,
  output logic      [NCH*5-1:0]     equalizerControl
);
  // ************************************************************
  // address decode
  // ************************************************************
  localparam int IW = $clog2(NCH);

  function automatic logic isChanCtrl(input logic [6:0] a);
    isChanCtrl = ((a & crxeq_pkg::CH_STRIDE_MASK) == crxeq_pkg::CH_CTRL_MATCH);
  endfunction : isChanCtrl

  wire logic          addrHit = isChanCtrl(hostReq.addr);
  wire logic [IW-1:0] chanIdx = hostReq.addr[crxeq_pkg::CH_SEL_LSB +: IW];
  wire logic          doWrite = hostReq.wrEn & addrHit;
  logic               rdHit_ff;
  logic [7:0]         memRd;
  logic [NCH*8-1:0]   allRegs;

  crxeq_regfile #(.DEPTH(NCH)) u_regs (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .clkEn     (clkEn),
    .wrEn      (doWrite),
    .wrIdx     (chanIdx),
    .wrData    (hostReq.wdata),
    .rdIdx     (chanIdx),
    .rdData_ff (memRd),
    .allRegs   (allRegs)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdHit_ff <= 1'b0;
    end else if (clkEn) begin
      rdHit_ff <= hostReq.rdEn & addrHit;
    end
  end

  // unmapped reads return zero
  assign rdData = rdHit_ff ? memRd : 8'h00;
  assign rdHit  = rdHit_ff;

  // ************************************************************
  // per-channel outputs
  // ************************************************************
  always_comb begin
    crxeq_pkg::crxeq_ctrl_type c;
    c = '0;
    for (int i = 0; i < NCH; i++) begin
      c = allRegs[i*8 +: 8];
      // strap mode overrides software so lines are never left deaf
      receiverPowerOn[i]       = c.receiverPowerOn | hardwareMode; // see R1 see R2 see R3 see R4
      equalizerControl[i*5 +: 5] = c.equalizerControl;           // see R5
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_hw_mode_on: assert property (@(posedge mclk) disable iff (!arst_n)
    hardwareMode |-> &receiverPowerOn) else $error("receiver off in hardware mode"); // see R4

  a_write_sets_rx: assert property (@(posedge mclk) disable iff (!arst_n)
    (clkEn && hostReq.wrEn && hostReq.addr == crxeq_pkg::CH1_CTRL_OFS)
    |=> receiverPowerOn[1] == ($past(hostReq.wdata[crxeq_pkg::RXON_POS]) | hardwareMode))
    else $error("rx on not following write"); // see R1

  a_write_clears_rx: assert property (@(posedge mclk) disable iff (!arst_n)
    (clkEn && hostReq.wrEn && hostReq.addr == crxeq_pkg::CH2_CTRL_OFS
     && !hostReq.wdata[crxeq_pkg::RXON_POS]) ##1 !hardwareMode |-> !receiverPowerOn[2])
    else $error("rx not shut down"); // see R2

  a_chan_isolated: assert property (@(posedge mclk) disable iff (!arst_n)
    (clkEn && hostReq.wrEn && hostReq.addr == crxeq_pkg::CH0_CTRL_OFS)
    |=> $stable(equalizerControl[19:5]))
    else $error("write leaked into other channel"); // see R3

  a_eq_field: assert property (@(posedge mclk) disable iff (!arst_n)
    (clkEn && hostReq.wrEn && hostReq.addr == crxeq_pkg::CH3_CTRL_OFS)
    |=> equalizerControl[19:15] == $past(hostReq.wdata[4:0]))
    else $error("equalizer field mismatch"); // see R5

  a_reset_zero: assert property (@(posedge mclk)
    $rose(arst_n) |-> equalizerControl == '0 && (hardwareMode || receiverPowerOn == '0))
    else $error("reset value not zero"); // see R6

  // ************************************************************
  // check helpers
  // ************************************************************
  // decoded once here so the per-channel checks below stay short
  wire logic       wrTaken = clkEn & hostReq.wrEn;
  wire logic       rdTaken = clkEn & hostReq.rdEn;
  wire logic       wrCh0   = wrTaken & (hostReq.addr == crxeq_pkg::CH0_CTRL_OFS);
  wire logic       wrCh1   = wrTaken & (hostReq.addr == crxeq_pkg::CH1_CTRL_OFS);
  wire logic       wrCh2   = wrTaken & (hostReq.addr == crxeq_pkg::CH2_CTRL_OFS);
  wire logic       wrCh3   = wrTaken & (hostReq.addr == crxeq_pkg::CH3_CTRL_OFS);
  wire logic       wrStray = wrTaken & ~addrHit;
  wire logic       wrRx    = hostReq.wdata[crxeq_pkg::RXON_POS];
  wire logic [4:0] wrEq    = hostReq.wdata[crxeq_pkg::EQC_LSB +: crxeq_pkg::EQC_W];

  // ************************************************************
  // per-channel write checks
  // ************************************************************
  a_ch0_rx_write: assert property (@(posedge mclk) disable iff (!arst_n) // see R1
    wrCh0 |=> receiverPowerOn[0] == ($past(wrRx) | hardwareMode))
    else $error("channel 0 rx on not following write");

  a_ch2_rx_write: assert property (@(posedge mclk) disable iff (!arst_n) // see R2
    wrCh2 |=> receiverPowerOn[2] == ($past(wrRx) | hardwareMode))
    else $error("channel 2 rx on not following write");

  a_ch3_rx_write: assert property (@(posedge mclk) disable iff (!arst_n) // see R1
    wrCh3 |=> receiverPowerOn[3] == ($past(wrRx) | hardwareMode))
    else $error("channel 3 rx on not following write");

  a_ch0_eq_write: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    wrCh0 |=> equalizerControl[4:0] == $past(wrEq))
    else $error("channel 0 equalizer field mismatch");

  a_ch1_eq_write: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    wrCh1 |=> equalizerControl[9:5] == $past(wrEq))
    else $error("channel 1 equalizer field mismatch");

  a_ch2_eq_write: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    wrCh2 |=> equalizerControl[14:10] == $past(wrEq))
    else $error("channel 2 equalizer field mismatch");

  // ************************************************************
  // channel isolation checks
  // ************************************************************
  a_ch1_eq_isolated: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrCh1 |=> $stable(equalizerControl[4:0]) && $stable(equalizerControl[19:10]))
    else $error("channel 1 write leaked");

  a_ch2_eq_isolated: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrCh2 |=> $stable(equalizerControl[9:0]) && $stable(equalizerControl[19:15]))
    else $error("channel 2 write leaked");

  a_ch3_eq_isolated: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrCh3 |=> $stable(equalizerControl[14:0]))
    else $error("channel 3 write leaked");

  // strap mode is held low across both cycles so it cannot mask a leak
  a_ch0_rx_isolated: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrCh0 && !hardwareMode ##1 !hardwareMode |-> $stable(receiverPowerOn[3:1]))
    else $error("channel 0 rx write leaked");

  a_ch1_rx_isolated: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrCh1 && !hardwareMode ##1 !hardwareMode
    |-> $stable(receiverPowerOn[0]) && $stable(receiverPowerOn[3:2]))
    else $error("channel 1 rx write leaked");

  a_ch2_rx_isolated: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrCh2 && !hardwareMode ##1 !hardwareMode
    |-> $stable(receiverPowerOn[1:0]) && $stable(receiverPowerOn[3]))
    else $error("channel 2 rx write leaked");

  a_ch3_rx_isolated: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrCh3 && !hardwareMode ##1 !hardwareMode |-> $stable(receiverPowerOn[2:0]))
    else $error("channel 3 rx write leaked");

  a_stray_eq_kept: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrStray |=> $stable(equalizerControl))
    else $error("unmapped write changed equalizer");

  a_stray_rx_kept: assert property (@(posedge mclk) disable iff (!arst_n) // see R3
    wrStray && !hardwareMode ##1 !hardwareMode |-> $stable(receiverPowerOn))
    else $error("unmapped write changed rx on");

  // ************************************************************
  // clock enable and read checks
  // ************************************************************
  a_freeze_eq: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    !clkEn |=> $stable(equalizerControl))
    else $error("equalizer moved while frozen");

  a_freeze_rx: assert property (@(posedge mclk) disable iff (!arst_n) // see R1
    !clkEn && !hardwareMode ##1 !hardwareMode |-> $stable(receiverPowerOn))
    else $error("rx on moved while frozen");

  a_freeze_rddata: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    !clkEn |=> $stable(rdData) && $stable(rdHit))
    else $error("read port moved while frozen");

  a_read_hit: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    rdTaken && addrHit |=> rdHit)
    else $error("read hit missing");

  a_read_miss: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    clkEn && !(hostReq.rdEn && addrHit) |=> !rdHit && rdData == 8'h00)
    else $error("read hit without request");

  // a write in the same cycle must not show through: the old value is read
  a_ch0_read_eq: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    rdTaken && hostReq.addr == crxeq_pkg::CH0_CTRL_OFS
    |=> rdData[4:0] == $past(equalizerControl[4:0]))
    else $error("channel 0 read data mismatch");

  a_ch1_read_eq: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    rdTaken && hostReq.addr == crxeq_pkg::CH1_CTRL_OFS
    |=> rdData[4:0] == $past(equalizerControl[9:5]))
    else $error("channel 1 read data mismatch");

  a_ch2_read_eq: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    rdTaken && hostReq.addr == crxeq_pkg::CH2_CTRL_OFS
    |=> rdData[4:0] == $past(equalizerControl[14:10]))
    else $error("channel 2 read data mismatch");

  a_ch3_read_eq: assert property (@(posedge mclk) disable iff (!arst_n) // see R5
    rdTaken && hostReq.addr == crxeq_pkg::CH3_CTRL_OFS
    |=> rdData[4:0] == $past(equalizerControl[19:15]))
    else $error("channel 3 read data mismatch");

  // no disable here: this one watches the reset itself
  a_reset_hold: assert property (@(posedge mclk) // see R6
    !arst_n |-> equalizerControl == '0 && !rdHit && rdData == 8'h00)
    else $error("state not cleared during reset");
endmodule : channel_rx_enable_eq_ctrl
`default_nettype wire

// ### channel_rx_enable_eq_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module channel_rx_enable_eq_ctrl_bench;
  logic                     mclk = 1'b0;
  logic                     arst_n;
  logic                     clkEn = 1'b1;
  logic                     hardwareMode = 1'b0;
  crxeq_pkg::crxeq_req_type hostReq = '0;
  logic [7:0]               rdData;
  logic                     rdHit;
  logic [3:0]               receiverPowerOn;
  logic [19:0]              equalizerControl;
  logic [3:0]               expRx = 4'h0;
  logic [19:0]              expEq = 20'h0;
  logic [7:0]               val [4] = '{8'he1, 8'h1f, 8'h3f, 8'h10};
  int                       n_mismatch = 0;
  int                       checks_done = 0;
  always #2 mclk = ~mclk;
  channel_rx_enable_eq_ctrl dut_u (.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn),
    .hardwareMode(hardwareMode), .hostReq(hostReq), .rdData(rdData), .rdHit(rdHit),
    .receiverPowerOn(receiverPowerOn), .equalizerControl(equalizerControl));
  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    hostReq = {1'b1, 1'b0, a, d};
    @(negedge mclk);
    hostReq = '0;
  endtask : wr
  // read data is registered on the taking edge and checked at the next falling edge
  task automatic rd(input logic [6:0] a, input logic hit, input logic [7:0] d);
    @(negedge mclk);
    hostReq = {1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    hostReq = '0;
    check(rdHit, hit);
    check(rdData, d);
  endtask : rd
  task automatic outs();
    check(receiverPowerOn, expRx);
    check(equalizerControl, expEq);
  endtask : outs
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    // start unknown so the drop to zero is a real edge for the async reset
    arst_n = 1'b0;
    repeat (16) @(negedge mclk);
    arst_n = 1'b1;
    outs();
    for (int i = 0; i < 4; i++) rd(7'(i * 16), 1'b1, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(7'(i * 16), val[i]);
      expRx[i] = val[i][5];
      expEq[i*5+:5] = val[i][4:0];
      outs();
    end
    for (int i = 0; i < 4; i++) rd(7'(i * 16), 1'b1, val[i]);
    wr(7'h20, 8'h0a);
    expRx[2] = 1'b0;
    expEq[14:10] = 5'h0a;
    outs();
    $display("test channels done");
    wr(7'h40, 8'hff);
    wr(7'h01, 8'hff);
    outs();
    rd(7'h11, 1'b0, 8'h00);
    clkEn = 1'b0;
    wr(7'h30, 8'h3f);
    clkEn = 1'b1;
    outs();
    $display("test refusals done");
    @(negedge mclk);
    hardwareMode = 1'b1;
    @(negedge mclk);
    check(receiverPowerOn, 4'hf);
    rd(7'h20, 1'b1, 8'h0a);
    hardwareMode = 1'b0;
    @(negedge mclk);
    outs();
    $display("test hardware mode done");
    arst_n = 1'b0;
    expRx = 4'h0;
    expEq = 20'h0;
    #1 outs();
    @(negedge mclk);
    arst_n = 1'b1;
    rd(7'h00, 1'b1, 8'h00);
    $display("test second reset done");
    end_sim();
  end
  // whole run is well under a thousand cycles
  initial begin
    #8000;
    n_mismatch++;
    end_sim();
  end
endmodule : channel_rx_enable_eq_ctrl_bench
`default_nettype wire
